// >>> common/ectu_regs.svh
// constants for the event capture timer unit
`ifndef ECTU_REGS_SVH
`define ECTU_REGS_SVH
`define ECTU_WIDTH        16
`define ECTU_MAX          16'hFFFF
`define ECTU_ZERO         16'h0000
`define ECTU_FILT_LEN     4
`define ECTU_PRE_W        10
`define ECTU_CLOCK_SOURCE_SELECT_W     2
`define ECTU_CLOCK_SOURCE_SELECT_DIV1  2'h0
`define ECTU_CLOCK_SOURCE_SELECT_DIV2  2'h1
`define ECTU_CLOCK_SOURCE_SELECT_COMP  2'h2
`define ECTU_MODE_W       3
`define ECTU_CAPTURE_COMPARE_VALUE_RESET   16'h0000
`endif

// >>> common/ectu_pkg.sv
// types for the event capture timer unit
package ectu_pkg;
    typedef enum logic [2:0] {
        ECTU_PERIODIC = 3'h0,
        ECTU_TIMEOUT  = 3'h1,
        ECTU_CAPTURE  = 3'h2,
        ECTU_FREQ     = 3'h3,
        ECTU_PULSE    = 3'h4,
        ECTU_FRQPW    = 3'h5
    } ectu_mode_e;

    // sequence state for the edge driven modes, one-hot
    typedef enum logic [3:0] {
        ECTU_SQ_IDLE  = 4'b0001,
        ECTU_SQ_RUN   = 4'b0010,
        ECTU_SQ_HIGH  = 4'b0100,
        ECTU_SQ_DONE  = 4'b1000
    } ectu_seq_e;

    typedef struct packed {
        logic [1:0]  sync;
        logic [3:0]  filt;
        logic        filt_out;
        logic        evt_prev;
        logic [9:0]  pre;
        logic [15:0] count;
        logic [15:0] capture_compare_value;
        logic        flag;
        logic        running;
        ectu_seq_e   seq;
        logic        irq;
        logic        evo;
    } ectu_state_s;
endpackage : ectu_pkg

// >>> rtl/ectu_timer.sv
// 16-bit event capture timer unit core
`timescale 1ns/10ps
`include "ectu_regs.svh"

// Contract
// - sixteen bit counter and capture value
// - filter passes input when four samples agree
// - filter adds four cycles, runs undivided
// - tick from own prescaler or companion
// - debug halt stops unless run_while_halted
// - reset selects periodic mode
// - enabled counter advances, value readable
// - periodic: count to top, flag, restart
// - top below count: wrap without flag
// - timeout: first edge restarts, second stops
// - timeout: flag if top before second
// - frozen: new edge restarts, reads ignored
// - capture: free run, copy count, flag
// - edge polarity selectable in timeout, capture and freq; pulse and combined use fixed rise and fall
// - upper byte read clears flag in capture modes
// - freq: capture, restart, flag each edge
// - pulse: rise restarts, fall captures
// - combined: rise start, fall capture, rise stop
// - combined: read clears, next rise zeroes
// - flag set pulses event output
// - irq while flag and enabled
module ectu_timer (
    input  wire logic                     CLK,
    input  wire logic                     NRST,
    input  wire logic                     ENABLE,
    input  wire logic [2:0]               MODE,
    input  wire logic [1:0]               CLOCK_SOURCE_SELECT,
    input  wire logic                     COMPANION_TIMER_A_TICK,
    input  wire logic                     FILTER_EN,
    input  wire logic                     EDGE_FALL,
    input  wire logic                     EVENT_EN,
    input  wire logic                     EVENT_IN,
    input  wire logic                     DEBUG_HALT,
    input  wire logic                     RUN_WHILE_HALTED,
    input  wire logic                     INT_EN,
    input  wire logic                     COUNT_WR,
    input  wire logic [15:0]              COUNT_WDATA,
    input  wire logic                     CAPTURE_COMPARE_VALUE_WR,
    input  wire logic [15:0]              CAPTURE_COMPARE_VALUE_WDATA,
    input  wire logic                     CAPTURE_COMPARE_VALUE_HI_RD,
    input  wire logic                     FLAG_CLR,
    output logic      [15:0]              COUNT_VALUE,
    output logic      [15:0]              CAPTURE_COMPARE_VALUE,
    output logic                          CAPTURE_FLAG,
    output logic                          RUNNING,
    output logic                          IRQ,
    output logic                          EVENT_OUT
);
    import ectu_pkg::*;

    ectu_state_s s_q;
    ectu_state_s s_d;
    ectu_mode_e  mode;
    logic        tick;
    logic        active;
    logic        sync_in;
    logic        evt_lvl;
    logic        edge_sel;
    logic        rise;
    logic        fall;
    logic        set_flag;
    logic        clr_flag;
    logic        at_top;

    assign mode    = ectu_mode_e'(MODE);
    assign sync_in = s_q.sync[1];

    // event is dropped while halted, like the counter itself
    assign active = ENABLE && (!DEBUG_HALT || RUN_WHILE_HALTED);

    // tick select; companion tick is already in our clock domain
    always_comb begin
        case (CLOCK_SOURCE_SELECT)
            `ECTU_CLOCK_SOURCE_SELECT_DIV1: tick = 1'b1;
            `ECTU_CLOCK_SOURCE_SELECT_DIV2: tick = s_q.pre[0];
            `ECTU_CLOCK_SOURCE_SELECT_COMP: tick = COMPANION_TIMER_A_TICK;
            default:           tick = 1'b1;
        endcase
    end

    // filtered level feeds the edge detector; raw otherwise
    assign evt_lvl  = FILTER_EN ? s_q.filt_out : sync_in;
    assign rise     = active && EVENT_EN && evt_lvl && !s_q.evt_prev;
    assign fall     = active && EVENT_EN && !evt_lvl && s_q.evt_prev;
    assign edge_sel = EDGE_FALL ? fall : rise;
    assign at_top   = (s_q.count == s_q.capture_compare_value);

    always_comb begin
        s_d = s_q;
        set_flag = 1'b0;
        s_d.sync = {s_q.sync[0], EVENT_IN};
        // filter samples every clock, not every tick
        s_d.filt = {s_q.filt[2:0], sync_in};
        // judge the window including this sample, else latency is five
        if (s_d.filt == 4'hF) begin
            s_d.filt_out = 1'b1;
        end else if (s_d.filt == 4'h0) begin
            s_d.filt_out = 1'b0;
        end
        s_d.evt_prev = evt_lvl;
        s_d.pre = active ? s_q.pre + 10'h001 : s_q.pre;

        if (active && tick && s_q.running) begin
            case (mode)
                ECTU_PERIODIC: begin
                    if (at_top) begin
                        s_d.count = `ECTU_ZERO;
                        set_flag = 1'b1;
                    end else begin
                        s_d.count = s_q.count + 16'h0001; // wraps past max
                    end
                end
                ECTU_TIMEOUT: begin
                    if (at_top && s_q.seq == ECTU_SQ_RUN) begin
                        set_flag = 1'b1;
                    end
                    s_d.count = s_q.count + 16'h0001;
                end
                default: s_d.count = s_q.count + 16'h0001;
            endcase
        end

        // edge actions per mode
        case (mode)
            ECTU_TIMEOUT: begin
                if (edge_sel) begin
                    if (s_q.seq == ECTU_SQ_RUN) begin
                        s_d.running = 1'b0;
                        s_d.seq = ECTU_SQ_DONE;
                    end else begin
                        s_d.count = `ECTU_ZERO;
                        s_d.running = 1'b1;
                        s_d.seq = ECTU_SQ_RUN;
                    end
                end
            end
            ECTU_CAPTURE: begin
                s_d.running = 1'b1;
                if (edge_sel) begin
                    s_d.capture_compare_value = s_q.count;
                    set_flag = 1'b1;
                end
            end
            ECTU_FREQ: begin
                s_d.running = 1'b1;
                if (edge_sel) begin
                    s_d.capture_compare_value = s_q.count;
                    s_d.count = `ECTU_ZERO;
                    set_flag = 1'b1;
                end
            end
            ECTU_PULSE: begin
                s_d.running = 1'b1;
                if (rise) begin
                    s_d.count = `ECTU_ZERO;
                    s_d.seq = ECTU_SQ_HIGH;
                end else if (fall && s_q.seq == ECTU_SQ_HIGH) begin
                    s_d.capture_compare_value = s_q.count;
                    s_d.seq = ECTU_SQ_IDLE;
                    set_flag = 1'b1;
                end
            end
            ECTU_FRQPW: begin
                case (s_q.seq)
                    ECTU_SQ_IDLE: begin
                        if (rise) begin
                            s_d.count = `ECTU_ZERO;
                            s_d.running = 1'b1;
                            s_d.seq = ECTU_SQ_HIGH;
                        end
                    end
                    ECTU_SQ_HIGH: begin
                        if (fall) begin
                            s_d.capture_compare_value = s_q.count;
                            s_d.seq = ECTU_SQ_RUN;
                        end
                    end
                    ECTU_SQ_RUN: begin
                        if (rise) begin
                            s_d.running = 1'b0;
                            s_d.seq = ECTU_SQ_DONE;
                            set_flag = 1'b1;
                        end
                    end
                    ECTU_SQ_DONE: begin
                        // re-armed by capture read or flag clear
                        if (CAPTURE_COMPARE_VALUE_HI_RD || FLAG_CLR) begin
                            s_d.seq = ECTU_SQ_IDLE;
                        end
                    end
                    default: s_d.seq = ECTU_SQ_IDLE;
                endcase
            end
            default: begin
                s_d.running = 1'b1;
                s_d.seq = ECTU_SQ_IDLE;
            end
        endcase

        if (!ENABLE) begin
            s_d.running = (mode != ECTU_TIMEOUT) && (mode != ECTU_FRQPW);
            s_d.seq = ECTU_SQ_IDLE;
        end

        // software writes win over counting
        if (COUNT_WR) begin
            s_d.count = COUNT_WDATA;
        end
        if (CAPTURE_COMPARE_VALUE_WR) begin
            s_d.capture_compare_value = CAPTURE_COMPARE_VALUE_WDATA;
        end

        // auto clear only in capture modes; set wins over clear
        clr_flag = FLAG_CLR || (CAPTURE_COMPARE_VALUE_HI_RD && mode != ECTU_PERIODIC
                   && mode != ECTU_TIMEOUT);
        if (set_flag) begin
            s_d.flag = 1'b1;
        end else if (clr_flag) begin
            s_d.flag = 1'b0;
        end
        s_d.evo = set_flag;
        s_d.irq = s_d.flag && INT_EN;

        if (!NRST) begin
            s_d = '0;
            s_d.capture_compare_value = `ECTU_CAPTURE_COMPARE_VALUE_RESET;
            s_d.running = 1'b1; // periodic mode is code zero
            s_d.seq = ECTU_SQ_IDLE;
        end
    end

    // single state register
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    assign COUNT_VALUE           = s_q.count;
    assign CAPTURE_COMPARE_VALUE = s_q.capture_compare_value;
    assign CAPTURE_FLAG          = s_q.flag;
    assign RUNNING               = s_q.running;
    assign IRQ                   = s_q.irq;
    assign EVENT_OUT             = s_q.evo;
endmodule : ectu_timer

// >>> tb/ectu_props.sv
// checker for the event capture timer unit
`timescale 1ns/10ps
module ectu_props (
    input wire logic        CLK, NRST, ENABLE, DEBUG_HALT, RUN_WHILE_HALTED, INT_EN,
    input wire logic        COUNT_WR, CAPTURE_COMPARE_VALUE_WR, CAPTURE_COMPARE_VALUE_HI_RD, FLAG_CLR,
    input wire logic        CAPTURE_FLAG, IRQ, EVENT_OUT,
    input wire logic [2:0]  MODE,
    input wire logic [1:0]  CLOCK_SOURCE_SELECT,
    input wire logic [15:0] COUNT_WDATA, COUNT_VALUE, CAPTURE_COMPARE_VALUE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // periodic count on the undivided clock, nothing overriding it
    wire run0 = ENABLE && MODE == 3'h0 && CLOCK_SOURCE_SELECT == 2'h0
        && !COUNT_WR && !CAPTURE_COMPARE_VALUE_WR && (!DEBUG_HALT || RUN_WHILE_HALTED);
    sequence at_top;
        run0 && COUNT_VALUE == CAPTURE_COMPARE_VALUE;
    endsequence
    sequence wrapped;
        COUNT_VALUE == 16'h0000 && CAPTURE_FLAG && EVENT_OUT;
    endsequence
    top_wrap_a: assert property (at_top |=> wrapped)
        else $error("no wrap at top");
    count_step_a: assert property (run0 && COUNT_VALUE != CAPTURE_COMPARE_VALUE
        |=> COUNT_VALUE == 16'($past(COUNT_VALUE) + 16'h0001) && !EVENT_OUT)
        else $error("bad count step");
    halt_hold_a: assert property (ENABLE && DEBUG_HALT && !RUN_WHILE_HALTED
        && !COUNT_WR |=> $stable(COUNT_VALUE)) else $error("count moved in halt");
    count_write_a: assert property (COUNT_WR |=> COUNT_VALUE == $past(COUNT_WDATA))
        else $error("count write lost");
    event_rise_a: assert property ($rose(CAPTURE_FLAG) |-> EVENT_OUT)
        else $error("flag without pulse");
    event_flag_a: assert property (EVENT_OUT |-> CAPTURE_FLAG)
        else $error("pulse without flag");
    irq_level_a: assert property (IRQ == (CAPTURE_FLAG && $past(INT_EN)))
        else $error("bad request");
    flag_clear_a: assert property (FLAG_CLR || CAPTURE_COMPARE_VALUE_HI_RD && MODE >= 3'h2
        |=> !CAPTURE_FLAG || EVENT_OUT) else $error("flag not cleared");
endmodule : ectu_props
bind ectu_timer ectu_props ectu_props_inst (.*);

// >>> tb/ectu_evsrc.sv
// event source model standing in for the routing network
`timescale 1ns/10ps
module ectu_evsrc (
    input  wire logic CLK,
    input  wire logic want,
    output logic      level
);
    logic [3:0] age_q = 4'h0;
    initial level = 1'b0;
    // every level stands two clocks at least, so no edge is lost
    always @(posedge CLK) begin
        if (want != level && age_q != 4'h0) begin
            level <= want;
            age_q <= 4'h0;
        end else if (age_q != 4'hF) begin
            age_q <= age_q + 4'h1;
        end
    end
endmodule : ectu_evsrc

// >>> tb/ectu_timer_tb_top.sv
// self-checking bench for the event capture timer unit
`timescale 1ns/10ps
module ectu_timer_tb_top;
    logic        CLK = 1'b0, NRST = 1'b0, ENABLE = 1'b0, COMPANION_TIMER_A_TICK = 1'b0;
    logic        FILTER_EN = 1'b0, EDGE_FALL = 1'b0, EVENT_EN = 1'b1, DEBUG_HALT = 1'b0;
    logic        RUN_WHILE_HALTED = 1'b0, INT_EN = 1'b1, COUNT_WR = 1'b0, CAPTURE_COMPARE_VALUE_WR = 1'b0;
    logic        CAPTURE_COMPARE_VALUE_HI_RD = 1'b0, FLAG_CLR = 1'b0, want = 1'b0;
    logic        EVENT_IN, CAPTURE_FLAG, RUNNING, IRQ, EVENT_OUT;
    logic [2:0]  MODE = 3'h0;
    logic [1:0]  CLOCK_SOURCE_SELECT = 2'h0;
    logic [15:0] COUNT_WDATA = 16'h0000, CAPTURE_COMPARE_VALUE_WDATA = 16'h0000;
    logic [15:0] COUNT_VALUE, CAPTURE_COMPARE_VALUE, caps[$];
    int          bad_count = 0, check_count = 0, cyc = 0, ev_cyc = 0, tk = 0;
    int          n, t, h, p, lat[2];
    ectu_timer ectu_timer_inst (.*);
    ectu_evsrc ectu_evsrc_inst (.CLK(CLK), .want(want), .level(EVENT_IN));
    initial forever #5 CLK = ~CLK;
    // companion tick one clock in three; log each event pulse
    always @(posedge CLK) begin
        tk <= (tk + 1) % 3;
        COMPANION_TIMER_A_TICK <= (tk == 0);
        #1 cyc++;
        if (EVENT_OUT === 1'b1) begin
            caps.push_back(CAPTURE_COMPARE_VALUE);
            ev_cyc = cyc;
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // periodic gap scales with the tick divider of the source
    function automatic logic [15:0] per(input int s, input int top);
        return 16'((top + 1) * (s + 1));
    endfunction : per
    // bounded wait; a lost event ends the run
    task automatic wait_evt(output int k);
        k = 0;
        do begin
            @(posedge CLK);
            #1 k++;
        end while (EVENT_OUT !== 1'b1 && k < 400);
        if (EVENT_OUT !== 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask : wait_evt
    task automatic wr(input logic c, input logic [15:0] d);
        @(posedge CLK);
        COUNT_WR <= c;
        CAPTURE_COMPARE_VALUE_WR <= ~c;
        COUNT_WDATA <= d;
        CAPTURE_COMPARE_VALUE_WDATA <= d;
        @(posedge CLK);
        COUNT_WR <= 1'b0;
        CAPTURE_COMPARE_VALUE_WR <= 1'b0;
    endtask : wr
    task automatic clr(input logic hi);
        @(posedge CLK);
        FLAG_CLR <= ~hi;
        CAPTURE_COMPARE_VALUE_HI_RD <= hi;
        @(posedge CLK);
        FLAG_CLR <= 1'b0;
        CAPTURE_COMPARE_VALUE_HI_RD <= 1'b0;
        #1 chk("flag", 16'h0000, {15'h0000, CAPTURE_FLAG});
    endtask : clr
    task automatic drv(input logic v, input int k);
        @(posedge CLK);
        want <= v;
        repeat (k) @(posedge CLK);
    endtask : drv
    // low first, so the high phase always starts with a fresh rise
    task automatic pulse_in(input logic [2:0] m, input int hi, input int lo);
        @(posedge CLK);
        caps.delete();
        MODE <= m;
        drv(1'b0, 4);
        drv(1'b1, hi);
        drv(1'b0, lo);
    endtask : pulse_in
    // a fresh rise must zero and start the counter again
    task automatic restart();
        drv(1'b0, 4);
        drv(1'b1, 4);
        #1 chk("restart count", 16'h0000, COUNT_VALUE);
        chk("restart run", 16'h0001, {15'h0000, RUNNING});
    endtask : restart
    initial begin
        void'($urandom(32'h4A8B69D4));
        repeat (20) @(posedge CLK);
        NRST <= 1'b1;
        #1 chk("count", 16'h0000, COUNT_VALUE);
        // period per tick source, then a short halt
        for (int s = 0; s < 3; s++) begin
            t = $urandom_range(40, 8);
            wr(1'b0, t[15:0]);
            CLOCK_SOURCE_SELECT <= s[1:0];
            wr(1'b1, 16'h0000);
            ENABLE <= 1'b1;
            wait_evt(n);
            wait_evt(n);
            chk("period", per(s, t), n[15:0]);
            @(posedge CLK);
            DEBUG_HALT <= 1'b1;
            repeat (6) @(posedge CLK);
            DEBUG_HALT <= 1'b0;
            clr(1'b0);
        end
        // top below count: runs through all ones first
        @(posedge CLK);
        CLOCK_SOURCE_SELECT <= 2'h0;
        wr(1'b0, 16'h0005);
        wr(1'b1, 16'hFFF0);
        wait_evt(n);
        chk("wrap gap", 16'h0016, n[15:0]);
        $display("periodic test done");
        // two captures on either polarity differ by one edge period
        for (int f = 0; f < 2; f++) begin
            @(posedge CLK);
            MODE <= 3'h2;
            EDGE_FALL <= f[0];
            wr(1'b1, 16'h0000);
            caps.delete();
            h = $urandom_range(9, 2);
            p = $urandom_range(9, 2);
            drv(1'b1, h);
            drv(1'b0, p);
            drv(1'b1, h);
            drv(1'b0, 12);
            chk("events", 16'h0002, 16'(caps.size()));
            chk("capture gap", 16'(h + p + 2), caps[1] - caps[0]);
            chk("irq", 16'h0001, {15'h0000, IRQ});
            clr(1'b1);
        end
        $display("capture test done");
        // latency with and without the filter, then a short pulse
        for (int f = 0; f < 2; f++) begin
            @(posedge CLK);
            FILTER_EN <= f[0];
            EDGE_FALL <= 1'b0;
            n = cyc;
            drv(1'b1, 20);
            lat[f] = ev_cyc - n;
            drv(1'b0, 20);
        end
        chk("filter delay", 16'h0004, 16'(lat[1] - lat[0]));
        caps.delete();
        drv(1'b1, 0);
        drv(1'b0, 20);
        chk("short pulse", 16'h0000, 16'(caps.size()));
        $display("filter test done");
        // freq runs while halted with run_while_halted set
        h = $urandom_range(9, 2);
        p = $urandom_range(9, 2);
        FILTER_EN <= 1'b0;
        DEBUG_HALT <= 1'b1;
        RUN_WHILE_HALTED <= 1'b1;
        pulse_in(3'h3, h, p);
        drv(1'b1, h);
        drv(1'b0, 12);
        chk("freq events", 16'h0002, 16'(caps.size()));
        chk("freq period", 16'(h + p + 1), caps[1]);
        DEBUG_HALT <= 1'b0;
        RUN_WHILE_HALTED <= 1'b0;
        pulse_in(3'h4, h, 12);
        chk("pulse events", 16'h0001, 16'(caps.size()));
        chk("pulse width", 16'(h), caps[0]);
        // combined: a rise while done is ignored until the read
        pulse_in(3'h5, h, p);
        drv(1'b1, 12);
        drv(1'b0, 4);
        drv(1'b1, 8);
        #1 chk("frqpw width", 16'(h), caps[0]);
        chk("frqpw events", 16'h0001, 16'(caps.size()));
        chk("frqpw count", 16'(h + p + 2), COUNT_VALUE);
        chk("frqpw run", 16'h0000, {15'h0000, RUNNING});
        clr(1'b1);
        restart();
        // timeout: far top gives no flag, near top flags before stop
        wr(1'b0, 16'h0100);
        pulse_in(3'h1, h, p);
        drv(1'b1, 12);
        #1 chk("timeout events", 16'h0000, 16'(caps.size()));
        chk("timeout count", 16'(h + p + 2), COUNT_VALUE);
        chk("timeout run", 16'h0000, {15'h0000, RUNNING});
        wr(1'b0, 16'h0003);
        caps.delete();
        restart();
        drv(1'b0, p);
        drv(1'b1, 12);
        #1 chk("timeout flag", 16'h0001, 16'(caps.size()));
        chk("timeout stop", 16'h0000, {15'h0000, RUNNING});
        // event input disabled: edges are refused
        EVENT_EN <= 1'b0;
        pulse_in(3'h2, h, 12);
        chk("gated events", 16'h0000, 16'(caps.size()));
        $display("mode test done");
        test_done();
    end
endmodule : ectu_timer_tb_top
